// ==== hdl/sleep_clock_gate_bank.sv ====
// sleep clock gating bank: AXI4-Lite register slave and unit clock enables
// assumes mode requests, run and deep-sleep enables and access strobes come
// from logic on aclk, so none of them is synchronised here
//
// Function
// - the sleep gating register is a 32-bit word at offset 0x114 of the system control base.
// - a gating bit of one clocks and enables its unit, a zero leaves it unclocked.
// - an access to an unclocked unit is answered with a bus fault.
// - reset clears every gating bit so the register reads zero.
// - the sleep register applies only in sleep; run uses its own enables, and deep sleep its own while auto gating is selected.
// - sleep gating applies only while auto gating is selected, else run enables stay.
// - bits 19 to 16 gate general-purpose counters 3 to 0, read and write.
// - bit 24 gates comparator 0, read and write, reset zero.
// - bit 12 gates two-wire unit 0, read and write, reset zero.
// - bit 8 gates quadrature encoder 0, read and write, reset zero.
// - bit 4 gates synchronous serial unit 0, read and write, reset zero.
// - bits 2 and 1 gate asynchronous serial units 2 and 1, read and write, reset zero.
// - bit 0 gates asynchronous serial unit 0, read and write, reset zero.
// - reserved bits are read-only and read as zero.
module sleep_clock_gate_bank
  import sleep_gate_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire sleep_gate_pkg::axil_req_s axil_req,
  output sleep_gate_pkg::axil_rsp_s axil_rsp,
  input wire logic sleep_req,
  input wire logic deep_req,
  input wire logic [31:0] run_gate_value,
  input wire logic [31:0] deep_gate_value,
  input wire logic [31:0] unit_access,
  output logic [31:0] unit_clk_en,
  output logic [31:0] unit_fault
);

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [31:0] sleep_clock_gate_ctl1;
  logic [31:0] next_sleep_clock_gate_ctl1;
  logic auto_gating_select;
  logic next_auto_gating_select;
  logic [31:0] sleep_snap;
  logic [31:0] next_sleep_snap;
  power_mode_e mode;
  power_mode_e next_mode;
  logic [31:0] next_unit_clk_en;
  logic [31:0] next_unit_fault;

  // ----------------------------------------
  // write channel state
  // ----------------------------------------
  axil_rsp_s next_rsp;
  logic aw_held;
  logic next_aw_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [ADDR_W-1:0] next_aw_addr;
  logic w_held;
  logic next_w_held;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0] w_strb;
  logic [3:0] next_w_strb;
  logic do_write;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFS_SLEEP_CTL1) || (a == OFS_AUTO_GATE) ||
           (a == OFS_APPLIED) || (a == OFS_MODE);
  endfunction

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------
  // bus slave and register file
  // ----------------------------------------
  always_comb begin
    logic aw_take;
    logic w_take;
    logic have_aw;
    logic have_w;
    logic [31:0] merged;
    aw_take = axil_req.awvalid && axil_rsp.awready;
    w_take = axil_req.wvalid && axil_rsp.wready;
    have_aw = aw_held || aw_take;
    have_w = w_held || w_take;
    merged = '0;
    wr_addr = aw_take ? axil_req.awaddr : aw_addr;
    wr_data = w_take ? axil_req.wdata : w_data;
    wr_strb = w_take ? axil_req.wstrb : w_strb;
    // address and data may arrive in either order; both wait for the other
    do_write = have_aw && have_w && !axil_rsp.bvalid;
    next_aw_held = have_aw && !do_write;
    next_aw_addr = aw_take ? axil_req.awaddr : aw_addr;
    next_w_held = have_w && !do_write;
    next_w_data = w_take ? axil_req.wdata : w_data;
    next_w_strb = w_take ? axil_req.wstrb : w_strb;
    next_rsp = axil_rsp;
    next_sleep_clock_gate_ctl1 = sleep_clock_gate_ctl1;
    next_auto_gating_select = auto_gating_select;
    if (axil_rsp.bvalid && axil_req.bready) begin
      next_rsp.bvalid = 1'b0;
    end
    if (do_write) begin
      next_rsp.bvalid = 1'b1;
      next_rsp.bresp = is_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      if (wr_addr == OFS_SLEEP_CTL1) begin
        merged = lane_merge(sleep_clock_gate_ctl1, wr_data, wr_strb);
        // reserved positions never store a one
        next_sleep_clock_gate_ctl1 = merged & GATE_MASK;
      end
      if (wr_addr == OFS_AUTO_GATE && wr_strb[0]) begin
        next_auto_gating_select = wr_data[POS_AUTO_GATING];
      end
    end
    next_rsp.awready = !next_aw_held && !next_rsp.bvalid;
    next_rsp.wready = !next_w_held && !next_rsp.bvalid;
    if (axil_rsp.rvalid && axil_req.rready) begin
      next_rsp.rvalid = 1'b0;
    end
    if (axil_req.arvalid && axil_rsp.arready) begin
      next_rsp.rvalid = 1'b1;
      next_rsp.rresp = is_mapped(axil_req.araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (axil_req.araddr)
        OFS_SLEEP_CTL1: next_rsp.rdata = sleep_clock_gate_ctl1;
        OFS_AUTO_GATE: next_rsp.rdata = {31'h00000000, auto_gating_select};
        OFS_APPLIED: next_rsp.rdata = unit_clk_en;
        OFS_MODE: next_rsp.rdata = {29'h00000000, mode};
        default: next_rsp.rdata = 32'h00000000;
      endcase
    end
    next_rsp.arready = !next_rsp.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      axil_rsp <= '0;
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      sleep_clock_gate_ctl1 <= SLEEP_CTL1_RESET;
      auto_gating_select <= 1'b0;
    end else begin
      axil_rsp <= next_rsp;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      sleep_clock_gate_ctl1 <= next_sleep_clock_gate_ctl1;
      auto_gating_select <= next_auto_gating_select;
    end
  end

  // ----------------------------------------
  // power mode and clock enables
  // ----------------------------------------
  // the sleep value is sampled on entry, so writes to it during sleep wait for the
  // next entry and never change a unit's clock mid-sleep
  always_comb begin
    next_mode = mode;
    next_sleep_snap = sleep_snap;
    if (deep_req) begin
      next_mode = MODE_DEEP;
    end else if (sleep_req) begin
      next_mode = MODE_SLEEP;
    end else begin
      next_mode = MODE_RUN;
    end
    if (next_mode == MODE_SLEEP && mode != MODE_SLEEP) begin
      next_sleep_snap = sleep_clock_gate_ctl1;
    end
    unique case (next_mode)
      MODE_SLEEP: next_unit_clk_en = auto_gating_select ? next_sleep_snap
                                                        : run_gate_value;
      MODE_DEEP: next_unit_clk_en = auto_gating_select ? deep_gate_value
                                                       : run_gate_value;
      default: next_unit_clk_en = run_gate_value;
    endcase
    next_unit_clk_en = next_unit_clk_en & GATE_MASK;
    next_unit_fault = unit_access & ~unit_clk_en;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= MODE_RUN;
      sleep_snap <= SLEEP_CTL1_RESET;
      unit_clk_en <= 32'h00000000;
      unit_fault <= 32'h00000000;
    end else begin
      mode <= next_mode;
      sleep_snap <= next_sleep_snap;
      unit_clk_en <= next_unit_clk_en;
      unit_fault <= next_unit_fault;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_reset_clears_gates: assert property (@(posedge aclk)
    $past(!aresetn) |-> sleep_clock_gate_ctl1 == 32'h00000000 && unit_clk_en == 32'h00000000)
    else $error("gating state not cleared by reset");

  chk_reserved_read_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (sleep_clock_gate_ctl1 & ~GATE_MASK) == 32'h00000000)
    else $error("reserved gating bit holds a one");

  chk_fault_unclocked: assert property (@(posedge aclk) disable iff (!aresetn)
    1'b1 |=> unit_fault == ($past(unit_access) & ~$past(unit_clk_en)))
    else $error("fault does not follow access to unclocked unit");

  chk_sleep_entry_apply: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MODE_RUN && sleep_req && !deep_req && auto_gating_select)
    |=> mode == MODE_SLEEP && unit_clk_en == $past(sleep_clock_gate_ctl1))
    else $error("sleep entry did not apply the sleep gates");

  chk_no_auto_run_gates: assert property (@(posedge aclk) disable iff (!aresetn)
    (sleep_req && !deep_req && !auto_gating_select)
    |=> unit_clk_en == ($past(run_gate_value) & GATE_MASK))
    else $error("run gates not kept without auto gating");

  chk_run_mode_gates: assert property (@(posedge aclk) disable iff (!aresetn)
    (!sleep_req && !deep_req) |=> mode == MODE_RUN ##0
    unit_clk_en == ($past(run_gate_value) & GATE_MASK))
    else $error("run mode not using run gates");

  chk_full_write_stores: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wr_addr == OFS_SLEEP_CTL1 && wr_strb == 4'hF)
    |=> sleep_clock_gate_ctl1 == ($past(wr_data) & GATE_MASK))
    else $error("write to gating register not stored");

  chk_unmapped_slverr: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && !is_mapped(wr_addr)) |=> axil_rsp.bvalid && axil_rsp.bresp == RESP_SLVERR)
    else $error("unmapped write not answered with slave error");

  chk_bresp_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (axil_rsp.bvalid && !axil_req.bready) |=> axil_rsp.bvalid && $stable(axil_rsp.bresp))
    else $error("write response dropped before taken");

  chk_read_back: assert property (@(posedge aclk) disable iff (!aresetn)
    (axil_req.arvalid && axil_rsp.arready && axil_req.araddr == OFS_SLEEP_CTL1)
    |=> axil_rsp.rvalid && axil_rsp.rdata == $past(sleep_clock_gate_ctl1))
    else $error("gating register read returned wrong data");

  chk_sleep_snap_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode == MODE_SLEEP && sleep_req && !deep_req && auto_gating_select)
    |=> $stable(sleep_snap) && unit_clk_en == $past(sleep_snap))
    else $error("sleep gates changed during sleep");

  chk_deep_gates: assert property (@(posedge aclk) disable iff (!aresetn)
    (deep_req && auto_gating_select)
    |=> mode == MODE_DEEP && unit_clk_en == ($past(deep_gate_value) & GATE_MASK))
    else $error("deep sleep not using deep gates");

  chk_enables_masked: assert property (@(posedge aclk) disable iff (!aresetn)
    (unit_clk_en & ~GATE_MASK) == 32'h00000000)
    else $error("enable raised for an unimplemented unit");

  chk_ctl1_write_only: assert property (@(posedge aclk) disable iff (!aresetn)
    !(do_write && wr_addr == OFS_SLEEP_CTL1) |=> $stable(sleep_clock_gate_ctl1))
    else $error("gating register changed without a write");

  chk_auto_gate_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_write && wr_addr == OFS_AUTO_GATE && wr_strb[0])
    |=> auto_gating_select == $past(wr_data[POS_AUTO_GATING]))
    else $error("auto gating select not written");

  chk_applied_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (axil_req.arvalid && axil_rsp.arready && axil_req.araddr == OFS_APPLIED)
    |=> axil_rsp.rdata == $past(unit_clk_en))
    else $error("applied enables read back wrong");

  chk_mode_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (axil_req.arvalid && axil_rsp.arready && axil_req.araddr == OFS_MODE)
    |=> axil_rsp.rdata == {29'h0, $past(mode)})
    else $error("power mode read back wrong");

  chk_no_fault_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    (unit_access == 32'h00000000) |=> unit_fault == 32'h00000000)
    else $error("fault raised without an access");

  // ----------------------------------------
  // bus protocol checks
  // ----------------------------------------
  chk_read_slverr: assert property (@(posedge aclk) disable iff (!aresetn)
    (axil_req.arvalid && axil_rsp.arready && !is_mapped(axil_req.araddr))
    |=> axil_rsp.rvalid && axil_rsp.rresp == RESP_SLVERR && axil_rsp.rdata == 32'h00000000)
    else $error("unmapped read not answered with slave error");

  chk_rdata_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    (axil_rsp.rvalid && !axil_req.rready)
    |=> axil_rsp.rvalid && $stable(axil_rsp.rdata) && $stable(axil_rsp.rresp))
    else $error("read data dropped before taken");

  chk_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write |=> axil_rsp.bvalid)
    else $error("write response not raised one cycle after write");

  chk_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (axil_req.arvalid && axil_rsp.arready) |=> axil_rsp.rvalid)
    else $error("read data not raised one cycle after address");

  chk_busy_no_ready: assert property (@(posedge aclk) disable iff (!aresetn)
    !(axil_rsp.bvalid && (axil_rsp.awready || axil_rsp.wready)) &&
    !(axil_rsp.rvalid && axil_rsp.arready))
    else $error("ready raised while a response is pending");

  // readies are still low at the first edge after reset, so that edge is skipped
  chk_idle_ready: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> axil_rsp.arready == !axil_rsp.rvalid &&
    axil_rsp.awready == (!aw_held && !axil_rsp.bvalid) &&
    axil_rsp.wready == (!w_held && !axil_rsp.bvalid))
    else $error("ready does not follow channel state");

  cov_sleep_entry: cover property (@(posedge aclk) disable iff (!aresetn)
    mode == MODE_RUN ##1 mode == MODE_SLEEP && unit_clk_en != 32'h00000000);
  cov_fault: cover property (@(posedge aclk) disable iff (!aresetn)
    unit_fault != 32'h00000000);
  cov_b_wait: cover property (@(posedge aclk) disable iff (!aresetn)
    axil_rsp.bvalid && !axil_req.bready);
  cov_r_wait: cover property (@(posedge aclk) disable iff (!aresetn)
    axil_rsp.rvalid && !axil_req.rready);
  cov_deep: cover property (@(posedge aclk) disable iff (!aresetn)
    mode == MODE_DEEP && auto_gating_select);

endmodule

// ==== hdl/sleep_gate_pkg.sv ====
// package for the sleep clock gating bank
// assumes an AXI4-Lite master with 32-bit data and a 12-bit offset window
package sleep_gate_pkg;

  // ----------------------------------------
  // address map
  // ----------------------------------------
  localparam logic [31:0] SYS_CTRL_BASE = 32'h400FE000;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_SLEEP_CTL1 = 12'h114;
  localparam logic [11:0] OFS_AUTO_GATE = 12'h200;
  localparam logic [11:0] OFS_APPLIED = 12'h204;
  localparam logic [11:0] OFS_MODE = 12'h208;

  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int POS_ASYNC_SERIAL0 = 0;
  localparam int POS_ASYNC_SERIAL1 = 1;
  localparam int POS_ASYNC_SERIAL2 = 2;
  localparam int POS_SYNC_SERIAL0 = 4;
  localparam int POS_QUAD_ENCODER0 = 8;
  localparam int POS_TWO_WIRE0 = 12;
  localparam int POS_GP_COUNTER0 = 16;
  localparam int POS_COMPARATOR0 = 24;
  localparam int POS_AUTO_GATING = 0;
  localparam logic [31:0] SLEEP_CTL1_RESET = 32'h00000000;
  localparam logic [31:0] GATE_MASK = 32'h010F1117;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_RUN = 3'h1,
    MODE_SLEEP = 3'h2,
    MODE_DEEP = 3'h4
  } power_mode_e;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_s;

endpackage

// ==== tb/tb.sv ====
// ----------------------------------------
// self-checking bench for the sleep clock gating bank
// ----------------------------------------
// assumes registered AXI4-Lite answers and applied enables on aclk
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sleep_gate_pkg::*;

  localparam logic [11:0] CTL1_OFS = 12'h114;
  localparam logic [31:0] WR_MASK = 32'h010F1117;
  logic aclk = 1'b0;
  logic aresetn;
  axil_req_s req;
  axil_rsp_s rsp;
  logic sleep_req;
  logic deep_req;
  logic [31:0] run_gate_value;
  logic [31:0] deep_gate_value;
  logic [31:0] unit_access;
  logic [31:0] unit_clk_en;
  logic [31:0] unit_fault;
  logic [31:0] rd;
  logic [1:0] resp;
  int failures = 0;
  int checks_done = 0;

  always #2 aclk = ~aclk;

  sleep_clock_gate_bank u_sleep_clock_gate_bank (
    .aclk(aclk),
    .aresetn(aresetn),
    .axil_req(req),
    .axil_rsp(rsp),
    .sleep_req(sleep_req),
    .deep_req(deep_req),
    .run_gate_value(run_gate_value),
    .deep_gate_value(deep_gate_value),
    .unit_access(unit_access),
    .unit_clk_en(unit_clk_en),
    .unit_fault(unit_fault)
  );

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // ----------------------------------------
  // bus master: hold each channel until its own ready
  // ----------------------------------------
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r,
                           input logic [3:0] s = 4'hF);
    bit done;
    done = 0;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= s;
    req.bready <= 1'b0;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      // the response is left waiting a cycle so the slave must hold it
      if (rsp.bvalid && req.bready) begin
        r = rsp.bresp;
        req.bready <= 1'b0;
        done = 1;
      end else if (rsp.bvalid) begin
        req.bready <= 1'b1;
      end
    end
    if (!done) begin
      failures++;
      print_verdict();
    end
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 0;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b0;
    for (int n = 0; n < 50 && !done; n++) begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid && req.rready) begin
        d = rsp.rdata;
        r = rsp.rresp;
        req.rready <= 1'b0;
        done = 1;
      end else if (rsp.rvalid) begin
        req.rready <= 1'b1;
      end
    end
    if (!done) begin
      failures++;
      print_verdict();
    end
  endtask

  // mode and enables settle within one edge; three leaves margin
  task automatic check_en(input string name, input logic [31:0] exp);
    repeat (3) @(posedge aclk);
    #1 check(name, exp, unit_clk_en);
  endtask

  initial begin
    aresetn = 1'b0;
    req = '0;
    sleep_req = 1'b0;
    deep_req = 1'b0;
    run_gate_value = 32'h00000000;
    deep_gate_value = 32'h00010000;
    unit_access = 32'h00000000;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // ----------------------------------------
    // reset state and field map
    // ----------------------------------------
    axi_read(CTL1_OFS, rd, resp);
    check("ctl1 reset", 32'h00000000, rd);
    check_en("en after reset", 32'h00000000);
    for (int i = 0; i < 32; i++) begin
      axi_write(CTL1_OFS, 32'h1 << i, resp);
      axi_read(CTL1_OFS, rd, resp);
      check("ctl1 bit", (32'h1 << i) & WR_MASK, rd);
      check("ctl1 resp", {30'h0, RESP_OKAY}, {30'h0, resp});
    end
    axi_write(12'h110, 32'hFFFFFFFF, resp);
    check("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    axi_read(12'h110, rd, resp);
    check("unmapped rdata", 32'h00000000, rd);
    axi_write(CTL1_OFS, 32'h00000011, resp);
    axi_read(CTL1_OFS, rd, resp);
    axi_write(CTL1_OFS, rd | 32'h00001000, resp);
    axi_read(CTL1_OFS, rd, resp);
    check("ctl1 rmw", 32'h00001011, rd);
    // only byte lane 1 is written; the other lanes keep their bits
    axi_write(CTL1_OFS, 32'hFFFFFFFF, resp, 4'h2);
    axi_read(CTL1_OFS, rd, resp);
    check("ctl1 lane write", 32'h00001111, rd);
    $display("test map done");
    // ----------------------------------------
    // sleep gating, faults, deferred update
    // ----------------------------------------
    run_gate_value <= 32'h00000011;
    check_en("run enables", 32'h00000011);
    axi_write(CTL1_OFS, 32'h01000004, resp);
    axi_write(OFS_AUTO_GATE, 32'h00000001, resp);
    sleep_req <= 1'b1;
    check_en("sleep enables", 32'h01000004);
    axi_read(OFS_APPLIED, rd, resp);
    check("applied enables", 32'h01000004, rd);
    @(posedge aclk);
    unit_access <= 32'h00000005;
    @(posedge aclk);
    unit_access <= 32'h00000000;
    #1 check("fault gated unit", 32'h00000001, unit_fault);
    axi_write(CTL1_OFS, 32'h00000100, resp);
    check_en("no change in sleep", 32'h01000004);
    sleep_req <= 1'b0;
    check_en("back to run", 32'h00000011);
    sleep_req <= 1'b1;
    check_en("next sleep entry", 32'h00000100);
    $display("test sleep done");
    // ----------------------------------------
    // deep sleep priority and auto gating off
    // ----------------------------------------
    deep_req <= 1'b1;
    check_en("deep enables", 32'h00010000);
    axi_read(OFS_MODE, rd, resp);
    check("mode deep", 32'h00000004, rd);
    deep_req <= 1'b0;
    axi_write(OFS_AUTO_GATE, 32'h00000000, resp);
    check_en("no auto gating", 32'h00000011);
    sleep_req <= 1'b0;
    $display("test modes done");
    print_verdict();
  end

endmodule
